// File: design/ctp_timer_pair.sv
// The AHB-Lite register port was left to the implementer.
module ctp_timer_pair #(
  parameter bit PAIR_B = 1'b0
) (
  // clock and reset
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  // ahb-lite slave
  input  wire logic                          hsel,
  input  wire logic [ctp_pkg::ADDR_W-1:0]    haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [ctp_pkg::DATA_W-1:0]    hwdata,
  input  wire logic                          hready,
  output logic                               hreadyout,
  output logic                               hresp,
  output logic [ctp_pkg::DATA_W-1:0]         hrdata,
  // processor power state
  input  wire logic                          cpu_sleep,
  input  wire logic                          cpu_idle,
  // timer pins
  input  wire logic                          low_external_count_pin,
  input  wire logic                          high_external_count_pin,
  // event outputs
  output logic                               irq_req,
  output logic                               adc_trigger,
  output logic [ctp_pkg::REG_W-1:0]          time_base_low,
  output logic [ctp_pkg::REG_W-1:0]          time_base_high
);
  import ctp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // address map of this instance
  // only the map and the peer outputs depend on the pair parameter
  localparam logic [15:0] O_LO_CNT = PAIR_B ? OFS_B_LO_CNT : OFS_A_LO_CNT;
  localparam logic [15:0] O_HOLD   = PAIR_B ? OFS_B_HOLD   : OFS_A_HOLD;
  localparam logic [15:0] O_HI_CNT = PAIR_B ? OFS_B_HI_CNT : OFS_A_HI_CNT;
  localparam logic [15:0] O_LO_PER = PAIR_B ? OFS_B_LO_PER : OFS_A_LO_PER;
  localparam logic [15:0] O_HI_PER = PAIR_B ? OFS_B_HI_PER : OFS_A_HI_PER;
  localparam logic [15:0] O_LO_CTL = PAIR_B ? OFS_B_LO_CTL : OFS_A_LO_CTL;
  localparam logic [15:0] O_HI_CTL = PAIR_B ? OFS_B_HI_CTL : OFS_A_HI_CTL;

  // index to byte address
  // offsets are word indices, four bytes apart on the bus
  function automatic logic [31:0] byte_addr(input logic [15:0] idx);
    byte_addr = {14'h0000, idx, 2'b00};
  endfunction

  // decode a bus address into a register select code
  function automatic logic [3:0] decode(input logic [31:0] a);
    // the map has no overlaps, so the order of the tests is moot
    decode = SEL_NONE;
    if (a == byte_addr(O_LO_CNT))
      decode = SEL_LO_CNT;
    if (a == byte_addr(O_HOLD))
      decode = SEL_HOLD;
    if (a == byte_addr(O_HI_CNT))
      decode = SEL_HI_CNT;
    if (a == byte_addr(O_LO_PER))
      decode = SEL_LO_PER;
    if (a == byte_addr(O_HI_PER))
      decode = SEL_HI_PER;
    if (a == byte_addr(O_LO_CTL))
      decode = SEL_LO_CTL;
    if (a == byte_addr(O_HI_CTL))
      decode = SEL_HI_CTL;
    if (a == byte_addr(OFS_IRQ_FLAG))
      decode = SEL_FLAG;
    if (a == byte_addr(OFS_IRQ_EN))
      decode = SEL_EN;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // timer helpers shared by both halves of the pair

  // counting allowed: on, not asleep, not stopped by idle
  // sleep stops both halves; idle stops only a half that asks for it
  function automatic logic running(input logic [15:0] ctl);
    running = ctl[CTL_ON] && !cpu_sleep
              && !(cpu_idle && ctl[CTL_IDLE_STOP]);
  endfunction

  // input event: pin rising edge, gated cycle or plain cycle
  // the pin is sampled once per clock, so an external clock above half
  // the bus clock loses edges
  function automatic logic source(input logic [15:0] ctl,
                                  input logic pin, input logic pin_q);
    if (ctl[CTL_CS])
      source = pin && !pin_q;
    else if (ctl[CTL_GATE])
      source = pin;
    else
      source = 1'b1;
  endfunction

  // gate falling edge ends accumulation and raises an event
  // not qualified by sleep: a gate fall still flags while counting halts
  function automatic logic gate_fall(input logic [15:0] ctl,
                                     input logic pin, input logic pin_q);
    gate_fall = ctl[CTL_ON] && ctl[CTL_GATE] && !ctl[CTL_CS]
                && pin_q && !pin;
  endfunction

  // prescaler step, returns {tick, next count}
  // a terminal count of zero gives a tick on every qualifying cycle
  function automatic logic [8:0] psc_step(input logic [15:0] ctl,
                                          input logic [7:0] psc);
    logic [7:0] term;
    term = PSC_T1;
    case (ctl[CTL_PSC_HI:CTL_PSC_LO])
      2'b01:   term = PSC_T8;
      2'b10:   term = PSC_T64;
      2'b11:   term = PSC_T256;
      default: term = PSC_T1;
    endcase
    if (psc >= term)
      psc_step = {1'b1, 8'h00};
    else
      psc_step = {1'b0, 8'(psc + 8'h01)};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // complete state of the block
  // one struct keeps the reset value and the next state in step
  typedef struct packed {
    ctp_bus_e    bus;
    logic [3:0]  sel;
    logic [15:0] lo_cnt;
    logic [15:0] hold;
    logic [15:0] hi_cnt;
    logic [15:0] lo_per;
    logic [15:0] hi_per;
    logic [15:0] lo_ctl;
    logic [15:0] hi_ctl;
    logic [7:0]  lo_psc;
    logic [7:0]  hi_psc;
    logic        lo_pin_q;
    logic        hi_pin_q;
    logic        irq_flag;
    logic        irq_en;
    logic        trig;
    logic [31:0] rdata;
  } ctp_state_s;

  ctp_state_s state_reg;
  ctp_state_s state_next;

  localparam ctp_state_s STATE_RESET = '{
    bus:      CTP_IDLE,
    sel:      SEL_NONE,
    lo_cnt:   CNT_RESET,
    hold:     CNT_RESET,
    hi_cnt:   CNT_RESET,
    lo_per:   PER_RESET,
    hi_per:   PER_RESET,
    lo_ctl:   CTL_RESET,
    hi_ctl:   CTL_RESET,
    lo_psc:   8'h00,
    hi_psc:   8'h00,
    lo_pin_q: 1'b0,
    hi_pin_q: 1'b0,
    irq_flag: 1'b0,
    irq_en:   1'b0,
    trig:     1'b0,
    rdata:    32'h0000_0000
  };

  ////////////////////////////////////////////////////////////////////////////
  // next state: timers first, then the bus, which overrides counting
  // the select code is registered with the address phase, so the address
  // bus is free for the next transfer during a data phase
  always_comb begin
    logic        chain;
    logic        set_evt;
    logic [8:0]  ps_lo;
    logic [8:0]  ps_hi;
    logic [31:0] cnt32;
    logic [31:0] per32;
    logic [15:0] wd;
    logic        accept;
    chain   = 1'b0;
    set_evt = 1'b0;
    ps_lo   = 9'h000;
    ps_hi   = 9'h000;
    cnt32   = 32'h0000_0000;
    per32   = 32'h0000_0000;
    wd      = hwdata[15:0];
    accept  = 1'b0;
    state_next          = state_reg;
    state_next.trig     = 1'b0;
    state_next.lo_pin_q = low_external_count_pin;
    state_next.hi_pin_q = high_external_count_pin;
    chain = state_reg.lo_ctl[CTL_CHAIN];

    // low timer prescaler; all setup comes from the low control register
    // clearing it while off means a restart never sees a stale count
    if (!state_reg.lo_ctl[CTL_ON])
      state_next.lo_psc = 8'h00;
    else if (running(state_reg.lo_ctl)
             && source(state_reg.lo_ctl, low_external_count_pin,
                       state_reg.lo_pin_q)) begin
      ps_lo = psc_step(state_reg.lo_ctl, state_reg.lo_psc);
      state_next.lo_psc = ps_lo[7:0];
    end

    if (chain) begin
      // high control bits ignored, high prescaler idle
      // the high control register may hold anything; it is not read here
      state_next.hi_psc = 8'h00;
      cnt32 = {state_reg.hi_cnt, state_reg.lo_cnt};
      per32 = {state_reg.hi_per, state_reg.lo_per};
      if (ps_lo[8]) begin
        // compare before stepping, so a zero period fires on every tick
        if (cnt32 == per32) begin
          cnt32   = 32'h0000_0000;
          set_evt = 1'b1;
          state_next.trig = !PAIR_B;
        end else begin
          cnt32 = cnt32 + 32'h0000_0001;
        end
      end
      state_next.hi_cnt = cnt32[31:16];
      state_next.lo_cnt = cnt32[15:0];
      if (gate_fall(state_reg.lo_ctl, low_external_count_pin,
                    state_reg.lo_pin_q))
        set_evt = 1'b1;
    end else begin
      // two independent 16-bit timers
      // the low half wraps quietly; only the high half raises events
      if (ps_lo[8]) begin
        if (state_reg.lo_cnt == state_reg.lo_per)
          state_next.lo_cnt = CNT_RESET;
        else
          state_next.lo_cnt = 16'(state_reg.lo_cnt + 16'h0001);
      end
      if (!state_reg.hi_ctl[CTL_ON])
        state_next.hi_psc = 8'h00;
      else if (running(state_reg.hi_ctl)
               && source(state_reg.hi_ctl, high_external_count_pin,
                         state_reg.hi_pin_q)) begin
        ps_hi = psc_step(state_reg.hi_ctl, state_reg.hi_psc);
        state_next.hi_psc = ps_hi[7:0];
      end
      if (ps_hi[8]) begin
        if (state_reg.hi_cnt == state_reg.hi_per) begin
          state_next.hi_cnt = CNT_RESET;
          set_evt = 1'b1;
          state_next.trig = !PAIR_B;
        end else begin
          state_next.hi_cnt = 16'(state_reg.hi_cnt + 16'h0001);
        end
      end
      if (gate_fall(state_reg.hi_ctl, high_external_count_pin,
                    state_reg.hi_pin_q))
        set_evt = 1'b1;
    end

    // data phase of a write: the bus wins over counting
    // a count write also clears its prescaler, so the next tick is a
    // whole prescale period away
    if (state_reg.bus == CTP_WRITE) begin
      case (state_reg.sel)
        SEL_LO_CNT: begin
          state_next.lo_cnt = wd;
          state_next.lo_psc = 8'h00;
          if (chain) begin
            state_next.hi_cnt = state_reg.hold;
            state_next.hi_psc = 8'h00;
          end
        end
        SEL_HOLD:   state_next.hold = wd;
        SEL_HI_CNT: begin
          state_next.hi_cnt = wd;
          state_next.hi_psc = 8'h00;
        end
        SEL_LO_PER: state_next.lo_per = wd;
        SEL_HI_PER: state_next.hi_per = wd;
        SEL_LO_CTL: state_next.lo_ctl = wd & LO_CTL_MASK;
        SEL_HI_CTL: state_next.hi_ctl = wd & HI_CTL_MASK;
        SEL_FLAG:   state_next.irq_flag = hwdata[IRQ_BIT];
        SEL_EN:     state_next.irq_en = hwdata[IRQ_BIT];
        default:    state_next.sel = state_reg.sel;
      endcase
    end

    // a new event beats a clear written in the same cycle; no auto clear
    // or-ing the event in after the write above is what makes set win
    state_next.irq_flag = state_next.irq_flag | set_evt;

    // read wait cycle: sample after any earlier write has landed
    // the hold latch follows every low count read, chained or not; an
    // unchained user simply never reads it
    if (state_reg.bus == CTP_RDWAIT) begin
      case (state_reg.sel)
        SEL_LO_CNT: begin
          state_next.rdata = {16'h0000, state_reg.lo_cnt};
          state_next.hold  = state_reg.hi_cnt;
        end
        SEL_HOLD:   state_next.rdata = {16'h0000, state_reg.hold};
        SEL_HI_CNT: state_next.rdata = {16'h0000, state_reg.hi_cnt};
        SEL_LO_PER: state_next.rdata = {16'h0000, state_reg.lo_per};
        SEL_HI_PER: state_next.rdata = {16'h0000, state_reg.hi_per};
        SEL_LO_CTL: state_next.rdata = {16'h0000, state_reg.lo_ctl};
        SEL_HI_CTL: state_next.rdata = {16'h0000, state_reg.hi_ctl};
        SEL_FLAG:
          state_next.rdata = 32'(state_reg.irq_flag) << IRQ_BIT;
        SEL_EN:
          state_next.rdata = 32'(state_reg.irq_en) << IRQ_BIT;
        default:    state_next.rdata = 32'h0000_0000;
      endcase
    end

    // bus sequencing; a new address phase is taken whenever ready is high
    // no address phase is taken in a read wait cycle; the master holds
    // its request until ready, so none is lost
    accept = (state_reg.bus != CTP_RDWAIT) && hready && hsel && htrans[1];
    case (state_reg.bus)
      CTP_RDWAIT: state_next.bus = CTP_RDDONE;
      CTP_IDLE, CTP_WRITE, CTP_RDDONE: begin
        if (accept) begin
          state_next.sel = decode(haddr);
          state_next.bus = hwrite ? CTP_WRITE : CTP_RDWAIT;
        end else begin
          state_next.bus = CTP_IDLE;
        end
      end
      default: state_next.bus = CTP_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  // the reset branch loads constants only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      state_reg <= STATE_RESET;
    else
      state_reg <= state_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs; reads take one wait state so read data comes from a flop
  // unmapped addresses read zero with OKAY rather than an error response
  assign hreadyout = (state_reg.bus != CTP_RDWAIT);
  assign hresp     = 1'b0;
  assign hrdata    = state_reg.rdata;
  // same flag and enable serve both modes
  // the enable gates only the request; the flag records events regardless
  assign irq_req   = state_reg.irq_flag && state_reg.irq_en;
  assign adc_trigger = state_reg.trig;
  // second pair offers no capture or compare time base
  assign time_base_low  = PAIR_B ? CNT_RESET : state_reg.lo_cnt;
  assign time_base_high = PAIR_B ? CNT_RESET : state_reg.hi_cnt;

endmodule

// File: pkg/ctp_pkg.sv
package ctp_pkg;

  // bus, register and prescaler widths
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int REG_W  = 16;
  localparam int PSC_W  = 8;

  // printed register offsets are word indices; byte address is index * 4
  localparam logic [15:0] OFS_A_LO_CNT  = 16'h0106;
  localparam logic [15:0] OFS_A_HOLD    = 16'h0108;
  localparam logic [15:0] OFS_A_HI_CNT  = 16'h010A;
  localparam logic [15:0] OFS_A_LO_PER  = 16'h010C;
  localparam logic [15:0] OFS_A_HI_PER  = 16'h010E;
  localparam logic [15:0] OFS_A_LO_CTL  = 16'h0110;
  localparam logic [15:0] OFS_A_HI_CTL  = 16'h0112;
  localparam logic [15:0] OFS_B_LO_CNT  = 16'h0114;
  localparam logic [15:0] OFS_B_HOLD    = 16'h0116;
  localparam logic [15:0] OFS_B_HI_CNT  = 16'h0118;
  localparam logic [15:0] OFS_B_LO_PER  = 16'h011A;
  localparam logic [15:0] OFS_B_HI_PER  = 16'h011C;
  localparam logic [15:0] OFS_B_LO_CTL  = 16'h011E;
  localparam logic [15:0] OFS_B_HI_CTL  = 16'h0120;
  // interrupt flag status and enable control, one copy per pair instance
  localparam logic [15:0] OFS_IRQ_FLAG  = 16'h0084;
  localparam logic [15:0] OFS_IRQ_EN    = 16'h008C;

  // control register fields
  localparam int CTL_ON        = 15;
  localparam int CTL_IDLE_STOP = 13;
  localparam int CTL_GATE      = 6;
  localparam int CTL_PSC_HI    = 5;
  localparam int CTL_PSC_LO    = 4;
  localparam int CTL_CHAIN     = 3;
  localparam int CTL_CS        = 1;
  localparam logic [15:0] LO_CTL_MASK = 16'hA07A;
  localparam logic [15:0] HI_CTL_MASK = 16'hA072;
  localparam int IRQ_BIT = 7;

  // reset values
  localparam logic [15:0] PER_RESET = 16'hFFFF;
  localparam logic [15:0] CTL_RESET = 16'h0000;
  localparam logic [15:0] CNT_RESET = 16'h0000;

  // prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
  localparam logic [7:0] PSC_T1   = 8'h00;
  localparam logic [7:0] PSC_T8   = 8'h07;
  localparam logic [7:0] PSC_T64  = 8'h3F;
  localparam logic [7:0] PSC_T256 = 8'hFF;

  // register select codes
  localparam logic [3:0] SEL_NONE   = 4'h0;
  localparam logic [3:0] SEL_LO_CNT = 4'h1;
  localparam logic [3:0] SEL_HOLD   = 4'h2;
  localparam logic [3:0] SEL_HI_CNT = 4'h3;
  localparam logic [3:0] SEL_LO_PER = 4'h4;
  localparam logic [3:0] SEL_HI_PER = 4'h5;
  localparam logic [3:0] SEL_LO_CTL = 4'h6;
  localparam logic [3:0] SEL_HI_CTL = 4'h7;
  localparam logic [3:0] SEL_FLAG   = 4'h8;
  localparam logic [3:0] SEL_EN     = 4'h9;

  // bus data-phase states
  typedef enum logic [3:0] {
    CTP_IDLE   = 4'b0001,
    CTP_WRITE  = 4'b0010,
    CTP_RDWAIT = 4'b0100,
    CTP_RDDONE = 4'b1000
  } ctp_bus_e;

endpackage

// File: testbench/ctp_checker.sv
module ctp_checker #(
  parameter bit PAIR_B = 1'b0
) (
  // clock and reset
  input wire logic                       hclk,
  input wire logic                       hresetn,
  // bus
  input wire logic                       hsel,
  input wire logic [1:0]                 htrans,
  input wire logic                       hwrite,
  input wire logic                       hready,
  input wire logic                       hreadyout,
  input wire logic [ctp_pkg::DATA_W-1:0] hrdata,
  // power state and events
  input wire logic                       cpu_sleep,
  input wire logic                       irq_req,
  input wire logic                       adc_trigger,
  input wire logic [ctp_pkg::REG_W-1:0]  time_base_low,
  input wire logic [ctp_pkg::REG_W-1:0]  time_base_high
);
  timeunit 1ns;
  timeprecision 1ps;
  import ctp_pkg::*;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic taken;
  // an address phase accepted by this slave
  assign taken = hsel && htrans[1] && hready && hreadyout;
  //////////////////////////////////////////////////////////////////////
  property p_read_wait;
    taken && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait");
  property p_write_ready;
    taken && hwrite |=> hreadyout;
  endproperty
  a_write_ready: assert property (p_write_ready) else $error("wr wait");
  property p_upper_zero;
    !hreadyout ##1 hreadyout |-> hrdata[31:16] == 16'h0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper");
  property p_no_trigger;
    PAIR_B |-> !adc_trigger;
  endproperty
  a_no_trigger: assert property (p_no_trigger) else $error("trigger");
  property p_no_base;
    PAIR_B |-> time_base_low == 16'h0000 && time_base_high == 16'h0000;
  endproperty
  a_no_base: assert property (p_no_base) else $error("time base");
  // bus traffic moves counts, so both count checks wait for a quiet bus
  property p_sleep;
    $past(cpu_sleep) && $past(cpu_sleep, 2) && $past(cpu_sleep, 3) &&
    !$past(hsel) && !$past(hsel, 2) && !$past(hsel, 3)
    |-> $stable(time_base_low) && $stable(time_base_high);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep count");
  property p_step;
    !$past(hsel) && !$past(hsel, 2) && !$past(hsel, 3) &&
    time_base_low != $past(time_base_low)
    |-> time_base_low == $past(time_base_low) + 16'h0001 ||
        time_base_low == 16'h0000;
  endproperty
  a_step: assert property (p_step) else $error("count step");
  property p_trig;
    adc_trigger |-> ##[0:1] time_base_high == 16'h0000;
  endproperty
  a_trig: assert property (p_trig) else $error("match wrap");
  property p_irq_fall;
    $fell(irq_req) |-> $past(hsel && htrans[1] && hwrite, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell");
endmodule

bind ctp_timer_pair ctp_checker #(.PAIR_B(PAIR_B)) i_ctp_checker (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .cpu_sleep(cpu_sleep), .irq_req(irq_req),
  .adc_trigger(adc_trigger), .time_base_low(time_base_low),
  .time_base_high(time_base_high));

// File: testbench/ctp_pin_model.sv
module ctp_pin_model (
  // clock
  input  wire logic       hclk,
  // pattern control
  input  wire logic       run,
  input  wire logic [7:0] half,
  // line into the timer
  output logic            pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_reg;
  // square wave while running; rests low between bursts so no stray edge
  always_ff @(posedge hclk) begin
    if (!run) begin
      pin     <= 1'b0;
      cnt_reg <= 8'h00;
    end else if (cnt_reg == half) begin
      pin     <= ~pin;
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
endmodule

// File: testbench/ctp_timer_pair_bench.sv
module ctp_timer_pair_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ctp_pkg::*;
  logic              hclk = 1'b0;
  logic              hresetn, cpu_sleep, cpu_idle;
  logic              hsel_a, hsel_b, bsel, hwrite;
  logic [1:0]        htrans;
  logic [ADDR_W-1:0] haddr;
  logic [DATA_W-1:0] hwdata, rd_a, rd_b, hrdata;
  logic              ro_a, ro_b, hready, run, pin, irq_a, irq_b;
  logic [7:0]        half;
  logic [2:0]        hsize;
  logic              trig_a, trig_b;
  logic              seen_a = 1'b0;
  logic              seen_b = 1'b0;
  logic [REG_W-1:0]  tbl_a, tbh_a, tbl_b, tbh_b, e;
  logic              p;
  int                mismatches = 0;
  int                total_checks = 0;
  // one bus, two slaves; the data phase follows the last addressed one
  assign hready = bsel ? ro_b : ro_a;
  assign hrdata = bsel ? rd_b : rd_a;
  always #2.5 hclk = ~hclk;
  // trigger pulses last one cycle, so keep a sticky record of each
  always @(posedge hclk) begin
    seen_a <= seen_a | trig_a;
    seen_b <= seen_b | trig_b;
  end
  // high pins share the line; the tests keep the high halves off it
  ctp_timer_pair #(.PAIR_B(1'b0)) i_ctp_timer_pair (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel_a), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(ro_a), .hresp(), .hrdata(rd_a),
    .cpu_sleep(cpu_sleep), .cpu_idle(cpu_idle),
    .low_external_count_pin(pin), .high_external_count_pin(pin),
    .irq_req(irq_a), .adc_trigger(trig_a),
    .time_base_low(tbl_a), .time_base_high(tbh_a));
  ctp_timer_pair #(.PAIR_B(1'b1)) i_ctp_timer_pair_b (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel_b), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(ro_b), .hresp(), .hrdata(rd_b),
    .cpu_sleep(cpu_sleep), .cpu_idle(cpu_idle),
    .low_external_count_pin(pin), .high_external_count_pin(pin),
    .irq_req(irq_b), .adc_trigger(trig_b),
    .time_base_low(tbl_b), .time_base_high(tbh_b));
  ctp_pin_model i_ctp_pin_model (
    .hclk(hclk), .run(run), .half(half), .pin(pin));
  //////////////////////////////////////////////////////////////////////
  // single transfer; waits on hready sampled before each edge
  task automatic xfer(input logic [15:0] ofs, input logic b, input logic wr,
                      input logic [15:0] wd, output logic [31:0] rd);
    hsel_a <= ~b;
    hsel_b <= b;
    bsel   <= b;
    haddr  <= {14'h0, ofs, 2'b00};
    hwrite <= wr;
    hsize  <= 3'h2;
    htrans <= 2'b10;
    do @(negedge hclk); while (hready !== 1'b1);
    @(posedge hclk);
    hsel_a <= 1'b0;
    hsel_b <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {16'h0000, wd};
    do @(negedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    @(posedge hclk);
  endtask
  task automatic wr(input logic [15:0] ofs, input logic b,
                    input logic [15:0] d);
    logic [31:0] r;
    xfer(ofs, b, 1'b1, d, r);
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [15:0] ofs, input logic b,
                     input logic [15:0] x);
    logic [31:0] r;
    xfer(ofs, b, 1'b0, 16'h0000, r);
    check(r, {16'h0000, x});
  endtask
  // irq seen at any point of an n-cycle window
  task automatic irq_win(input int n, input logic x);
    logic s;
    s = 1'b0;
    repeat (n) begin
      @(negedge hclk);
      s = s | irq_a;
    end
    check({31'h0, s}, {31'h0, x});
    @(posedge hclk);
  endtask
  // let control changes settle, then see whether the low count moves
  task automatic hold_chk(input logic x);
    logic [15:0] v;
    repeat (4) @(negedge hclk);
    v = tbl_a;
    repeat (20) @(negedge hclk);
    check({31'h0, tbl_a === v}, {31'h0, x});
    @(posedge hclk);
  endtask
  // first full interval between count changes
  task automatic gap(input logic [31:0] x);
    logic [15:0] v;
    int          n;
    @(negedge hclk);
    v = tbl_a;
    while (tbl_a === v) @(negedge hclk);
    v = tbl_a;
    n = 0;
    while (tbl_a === v) begin
      @(negedge hclk);
      n++;
    end
    check(n, x);
    @(posedge hclk);
  endtask
  task automatic test_done();
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  // watchdog, generous against the thousand or so cycles of the run
  initial begin
    repeat (10000) @(posedge hclk);
    mismatches++;
    $display("wrong value at %0t: watchdog expired", $time);
    test_done();
  end
  // main sequence
  initial begin
    {hresetn, cpu_sleep, cpu_idle, run, hsel_a, hsel_b, bsel} = 7'h00;
    {hwrite, htrans, hsize, haddr, hwdata} = '0;
    half = 8'h0A;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(OFS_A_LO_PER, 1'b0, 16'hFFFF);
    rdc(OFS_A_HI_PER, 1'b0, 16'hFFFF);
    rdc(OFS_A_LO_CTL, 1'b0, 16'h0000);
    rdc(16'h0200, 1'b0, 16'h0000);
    wr(OFS_A_LO_CTL, 1'b0, 16'hFFFF);
    rdc(OFS_A_LO_CTL, 1'b0, 16'hA07A);
    wr(OFS_A_HI_CTL, 1'b0, 16'hFFFF);
    rdc(OFS_A_HI_CTL, 1'b0, 16'hA072);
    wr(OFS_A_LO_CTL, 1'b0, 16'h0000);
    wr(OFS_A_HI_CNT, 1'b0, 16'hAAAA);
    wr(OFS_A_HOLD, 1'b0, 16'h1111);
    wr(OFS_A_LO_CNT, 1'b0, 16'h5678);
    rdc(OFS_A_HI_CNT, 1'b0, 16'hAAAA);
    wr(OFS_A_LO_CTL, 1'b0, 16'h0008);
    rdc(OFS_A_LO_CNT, 1'b0, 16'h5678);
    rdc(OFS_A_HOLD, 1'b0, 16'hAAAA);
    wr(OFS_A_HOLD, 1'b0, 16'h0001);
    wr(OFS_A_LO_CNT, 1'b0, 16'h0000);
    rdc(OFS_A_HI_CNT, 1'b0, 16'h0001);
    // chained run from 0x10000 to a 0x10003 period, high control wild
    wr(OFS_A_HI_CTL, 1'b0, 16'h8000);
    wr(OFS_A_LO_PER, 1'b0, 16'h0003);
    wr(OFS_A_HI_PER, 1'b0, 16'h0001);
    wr(OFS_IRQ_EN, 1'b0, 16'h0080);
    irq_win(5, 1'b0);
    wr(OFS_A_LO_CTL, 1'b0, 16'h8008);
    irq_win(20, 1'b1);
    check({31'h0, seen_a}, 32'h1);
    wr(OFS_A_LO_CTL, 1'b0, 16'h0008);
    rdc(OFS_A_HI_CNT, 1'b0, 16'h0000);
    rdc(OFS_IRQ_FLAG, 1'b0, 16'h0080);
    wr(OFS_IRQ_FLAG, 1'b0, 16'h0000);
    irq_win(3, 1'b0);
    wr(OFS_IRQ_FLAG, 1'b0, 16'h0080);
    wr(OFS_IRQ_EN, 1'b0, 16'h0000);
    irq_win(3, 1'b0);
    wr(OFS_IRQ_EN, 1'b0, 16'h0080);
    irq_win(3, 1'b1);
    wr(OFS_IRQ_FLAG, 1'b0, 16'h0000);
    wr(OFS_A_HI_CTL, 1'b0, 16'h0000);
    // gated accumulation: a short high pulse, its fall flags
    wr(OFS_A_LO_CTL, 1'b0, 16'h8048);
    run <= 1'b1;
    while (pin !== 1'b1) @(negedge hclk);
    @(posedge hclk);
    run <= 1'b0;
    irq_win(10, 1'b1);
    wr(OFS_IRQ_FLAG, 1'b0, 16'h0000);
    // external clock: count the pin's rising edges ourselves
    wr(OFS_A_LO_CTL, 1'b0, 16'h0008);
    wr(OFS_A_HOLD, 1'b0, 16'h0000);
    wr(OFS_A_LO_CNT, 1'b0, 16'h0000);
    wr(OFS_A_LO_CTL, 1'b0, 16'h800A);
    half <= 8'h02;
    run <= 1'b1;
    e = 16'h0000;
    p = 1'b0;
    repeat (100) begin
      @(negedge hclk);
      if (pin && !p) e++;
      p = pin;
    end
    @(posedge hclk);
    run <= 1'b0;
    @(negedge hclk);
    if (pin && !p) e++;
    repeat (8) @(posedge hclk);
    rdc(OFS_A_LO_CNT, 1'b0, e);
    // 16-bit low timer: sleep, idle stop, then each prescale
    wr(OFS_A_LO_CTL, 1'b0, 16'h0000);
    wr(OFS_A_LO_PER, 1'b0, 16'hFFFF);
    wr(OFS_A_LO_CTL, 1'b0, 16'h8000);
    cpu_sleep <= 1'b1;
    hold_chk(1'b1);
    cpu_sleep <= 1'b0;
    cpu_idle <= 1'b1;
    wr(OFS_A_LO_CTL, 1'b0, 16'hA000);
    hold_chk(1'b1);
    wr(OFS_A_LO_CTL, 1'b0, 16'h8000);
    hold_chk(1'b0);
    cpu_idle <= 1'b0;
    gap(32'd1);
    wr(OFS_A_LO_CTL, 1'b0, 16'h8010);
    gap(32'd8);
    wr(OFS_A_LO_CTL, 1'b0, 16'h8020);
    gap(32'd64);
    wr(OFS_A_LO_CTL, 1'b0, 16'h8030);
    gap(32'd256);
    // second pair: same logic at its own map, no outputs to peers
    rdc(OFS_B_LO_PER, 1'b1, 16'hFFFF);
    wr(OFS_B_LO_CTL, 1'b1, 16'h0008);
    wr(OFS_B_HOLD, 1'b1, 16'h5A5A);
    wr(OFS_B_LO_CNT, 1'b1, 16'h0001);
    rdc(OFS_B_HI_CNT, 1'b1, 16'h5A5A);
    // a short chained period: the flag rises, the trigger stays quiet
    wr(OFS_B_LO_PER, 1'b1, 16'h0004);
    wr(OFS_B_HI_PER, 1'b1, 16'h5A5A);
    wr(OFS_IRQ_EN, 1'b1, 16'h0080);
    wr(OFS_B_LO_CTL, 1'b1, 16'h8008);
    repeat (10) @(posedge hclk);
    check({tbl_b, tbh_b}, 32'h0);
    check({30'h0, irq_b, seen_b}, 32'h2);
    test_done();
  end
endmodule
